// ==== dram_dll_mode_freq_change_leveling.sv ====
// idle commands, delay-loop mode, read window start and write leveling feedback
//
// Operation
// - nop registers nothing, running work continues
// - deselect ignores inputs, running work continues
// - mode register 1 bit 0 turns loop off
// - loop off starts read window cycle early
// - clock ignored during self refresh
// - strobe edge samples clock, fed back on data
// - each byte lane reports its own strobe
// - mode register 1 bit 7 enters leveling
`timescale 1ns/10ps
module dram_dll_mode_freq_change_leveling
	import dram_seq_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ck,                              // link clock, sampled
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [1:0] upper_lane_strobe_pair,    // [1] true, [0] complement
	input wire logic [1:0] lower_lane_strobe_pair,    // [1] true, [0] complement
	output logic dll_off,                             // delay loop disabled
	output logic wl_active,                           // write leveling mode
	output logic self_refresh,                        // in self refresh
	output logic dll_reset_pulse,                     // delay loop reset request
	output logic read_window,                         // read strobe window starts
	output logic [4:0] read_latency,                  // current read latency in edges
	output logic [DQ_W-1:0] dq_out,                   // leveling feedback
	output logic [DQ_W-1:0] dq_oe                     // data driven by the device
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser, first stage read only by the second
	logic [SYNC_W-1:0] sync1;   // first stage
	logic [SYNC_W-1:0] pins;    // second stage, safe to use
	logic ck_prev;              // previous link clock level
	logic cke_prev;             // cke at the previous link edge
	logic [LANES-1:0] strb_prev; // previous lane strobe rise condition

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1 <= '0;
			pins <= '0;
		end
		else
		begin
			sync1 <= {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
				upper_lane_strobe_pair, lower_lane_strobe_pair};
			pins <= sync1;
		end
	end

	// unpacked synchronised pins
	logic s_ck, s_cke, s_cs_n;
	logic [2:0] s_cmd;
	logic [BANK_W-1:0] s_ba;
	logic [ADDR_W-1:0] s_addr;
	logic [1:0] s_up, s_lo;
	assign {s_ck, s_cke, s_cs_n, s_cmd, s_ba, s_addr, s_up, s_lo} = pins;

	// rising link clock edge in the system clock domain
	logic ck_edge;
	assign ck_edge = s_ck && !ck_prev;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ck_prev <= 1'b0;
		else
			ck_prev <= s_ck;
	end

	////////////////////////////////////////////////////////////////////////////
	// command decode at a link edge; deselect and nop start nothing
	logic sel;        // chip selected with cke high and not in self refresh
	logic do_mrs;
	logic do_rd;
	logic do_sre;     // self refresh entry
	assign sel = ck_edge && !s_cs_n && s_cke && cke_prev && !self_refresh;
	assign do_mrs = sel && s_cmd == CMD_MRS;
	assign do_rd = sel && s_cmd == CMD_RD && !wl_active;
	assign do_sre = ck_edge && !s_cs_n && cke_prev && !s_cke && s_cmd == CMD_REF
		&& !self_refresh;

	// cke history on link edges
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cke_prev <= 1'b0;
		else if (ck_edge)
			cke_prev <= s_cke;
	end

	// self refresh: clock and commands are don't care until cke rises
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			self_refresh <= 1'b0;
		else if (do_sre)
			self_refresh <= 1'b1;
		else if (ck_edge && s_cke)
			self_refresh <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// mode register fields
	logic [2:0] cl_code;
	logic [1:0] al_code;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			dll_off <= MR1_DLL_OFF_RST;
			wl_active <= MR1_WL_RST;
			al_code <= MR1_AL_RST;
			cl_code <= MR0_CL_RST;
		end
		else if (do_mrs && s_ba == MR1_SEL)
		begin
			dll_off <= s_addr[MR1_DLL_OFF_BIT];
			wl_active <= s_addr[MR1_WL_BIT];
			al_code <= s_addr[MR1_AL_LO+1:MR1_AL_LO];
		end
		else if (do_mrs && s_ba == MR0_SEL)
			cl_code <= s_addr[MR0_CL_LO+2:MR0_CL_LO];
	end

	// delay loop reset request pulse
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			dll_reset_pulse <= 1'b0;
		else
			dll_reset_pulse <= do_mrs && s_ba == MR0_SEL && s_addr[MR0_DLL_RST_BIT];
	end

	////////////////////////////////////////////////////////////////////////////
	// read latency: additive plus cas, one less with the loop off
	logic [4:0] cl;
	logic [4:0] al;
	logic [4:0] next_read_latency;
	assign cl = CL_BASE + {2'h0, cl_code};

	always_comb
	begin
		case (al_code)
			2'h1: al = cl - 5'h01;
			2'h2: al = cl - 5'h02;
			default: al = 5'h00;
		endcase
		next_read_latency = al + cl - {4'h0, dll_off};
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			read_latency <= CL_BASE + {2'h0, MR0_CL_RST};
		else
			read_latency <= next_read_latency;
	end

	// latency pipeline keeps shifting whatever commands follow
	logic [RD_PIPE_W-1:0] rd_pipe;
	logic [RD_PIPE_W-1:0] rd_insert;
	assign rd_insert = do_rd ? (RD_PIPE_W'(1) << (read_latency - 5'h01)) : '0;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rd_pipe <= '0;
		else if (ck_edge)
			rd_pipe <= {1'b0, rd_pipe[RD_PIPE_W-1:1]} | rd_insert;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			read_window <= 1'b0;
		else
			read_window <= ck_edge && rd_pipe[0];
	end

	////////////////////////////////////////////////////////////////////////////
	// per-lane leveling feedback, upper lane on upper data bits
	wl_lane_if lane_if [LANES] ();
	logic [LANES-1:0] strb_now;
	assign strb_now = {s_up[1] && !s_up[0], s_lo[1] && !s_lo[0]};

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			strb_prev <= '0;
		else
			strb_prev <= strb_now;
	end

	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			assign lane_if[g].enable = wl_active;
			assign lane_if[g].ck_level = s_ck;
			assign lane_if[g].strobe_rise = strb_now[g] && !strb_prev[g];
			wl_lane_sampler u_sampler (
				.clk(clk),
				.sys_rst(sys_rst),
				.lane(lane_if[g])
			);
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					dq_out[g*LANE_W +: LANE_W] <= '0;
					dq_oe[g*LANE_W +: LANE_W] <= '0;
				end
				else
				begin
					dq_out[g*LANE_W +: LANE_W] <= {LANE_W{lane_if[g].feedback}};
					dq_oe[g*LANE_W +: LANE_W] <= {LANE_W{wl_active}};
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	nop_no_effect_a: assert property (ck_edge && !s_cs_n && s_cmd == CMD_NOP
		|=> $stable(dll_off) && $stable(wl_active) && !dll_reset_pulse)
		else $error("nop changed mode state");
	desel_no_effect_a: assert property (ck_edge && s_cs_n
		|=> $stable(dll_off) && $stable(wl_active) && !dll_reset_pulse)
		else $error("deselect changed mode state");
	desel_keeps_read_a: assert property (ck_edge && s_cs_n && rd_pipe[0]
		|=> read_window)
		else $error("deselect dropped a running read");
	dll_off_set_a: assert property (do_mrs && s_ba == MR1_SEL
		|=> dll_off == $past(s_addr[MR1_DLL_OFF_BIT]))
		else $error("loop off bit not taken");
	early_window_a: assert property (dll_off ##2 1
		|-> read_latency == al + cl - 5'h01 || $changed(dll_off) || $changed(cl_code)
			|| $changed(al_code))
		else $error("loop off latency not one less");
	refresh_ignores_a: assert property (self_refresh && !s_cke
		|=> $stable(dll_off) && $stable(cl_code) && $stable(wl_active))
		else $error("command taken during self refresh");
	lane_split_a: assert property (##1 !sys_rst ##1 1 |-> dq_out[DQ_W-1:LANE_W] ==
		{LANE_W{$past(lane_if[1].feedback)}} && dq_out[LANE_W-1:0] ==
		{LANE_W{$past(lane_if[0].feedback)}})
		else $error("lane feedback mixed");
	level_enter_a: assert property (do_mrs && s_ba == MR1_SEL && s_addr[MR1_WL_BIT]
		|=> wl_active ##1 dq_oe == {DQ_W{1'b1}})
		else $error("leveling not entered");

	rd_cov: cover property (do_rd ##[1:1000] read_window);
	off_cov: cover property (dll_off && do_rd);
	sr_cov: cover property (do_sre ##[1:1000] !self_refresh);
	wl_cov: cover property (wl_active && lane_if[1].strobe_rise);
endmodule : dram_dll_mode_freq_change_leveling

// ==== dram_seq_pkg.sv ====
// constants shared by the idle-command, delay-loop mode and leveling logic
package dram_seq_pkg;
	localparam int ADDR_W = 14;              // address pins
	localparam int BANK_W = 3;               // bank address pins
	localparam int DQ_W = 16;                // data pins, two byte lanes
	localparam int LANE_W = 8;               // data bits per lane
	localparam int LANES = 2;                // upper and lower lanes
	localparam int SYNC_W = 27;              // width of the synchronised pin bundle
	localparam int RD_PIPE_W = 32;           // read latency pipeline depth in link edges
	// command codes {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_MRS = 3'h0;   // mode register set
	localparam logic [2:0] CMD_REF = 3'h1;   // refresh, self refresh with cke low
	localparam logic [2:0] CMD_RD = 3'h5;    // read
	localparam logic [2:0] CMD_NOP = 3'h7;   // no operation
	// mode register selects on the bank pins
	localparam logic [2:0] MR0_SEL = 3'h0;
	localparam logic [2:0] MR1_SEL = 3'h1;
	// field positions
	localparam int MR1_DLL_OFF_BIT = 0;      // delay loop off
	localparam int MR1_WL_BIT = 7;           // write leveling enable
	localparam int MR1_AL_LO = 3;            // additive latency code, two bits
	localparam int MR0_DLL_RST_BIT = 8;      // delay loop reset
	localparam int MR0_CL_LO = 4;            // latency code, three bits
	localparam logic [4:0] CL_BASE = 5'h04;  // latency = code plus this
	// reset values
	localparam logic MR1_DLL_OFF_RST = 1'b0;
	localparam logic MR1_WL_RST = 1'b0;
	localparam logic [2:0] MR0_CL_RST = 3'h2;
	localparam logic [1:0] MR1_AL_RST = 2'h0;
endpackage : dram_seq_pkg

// ==== wl_lane_if.sv ====
// per-lane link between the sequencer and a leveling sampler
`timescale 1ns/10ps
interface wl_lane_if;
	logic enable;       // leveling active
	logic ck_level;     // synchronised link clock level
	logic strobe_rise;  // one-cycle pulse on a rising lane strobe
	logic feedback;     // sampled clock level
	modport lane (input enable, input ck_level, input strobe_rise, output feedback);
	modport ctrl (output enable, output ck_level, output strobe_rise, input feedback);
endinterface : wl_lane_if

// ==== wl_lane_sampler.sv ====
// samples the link clock level on each rising lane strobe during leveling
`timescale 1ns/10ps
module wl_lane_sampler
	import dram_seq_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	wl_lane_if.lane lane
);
	////////////////////////////////////////////////////////////////////////////
	// capture flop, held between strobe edges
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			lane.feedback <= 1'b0;
		else if (lane.enable && lane.strobe_rise)
			lane.feedback <= lane.ck_level;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sample_on_edge_a: assert property (lane.enable && lane.strobe_rise |=>
		lane.feedback == $past(lane.ck_level))
		else $error("feedback does not hold clock level at strobe edge");
	hold_between_a: assert property (!lane.strobe_rise |=> $stable(lane.feedback))
		else $error("feedback changed without strobe edge");
endmodule : wl_lane_sampler

// ==== ctrl_model.sv ====
// controller-side model: link clock, command pins and lane strobes
`timescale 1ns/10ps
module ctrl_model
	import dram_seq_pkg::*;
(
	input wire logic clk,
	output logic ck,
	output logic cke,
	output logic cs_n,
	output logic [2:0] cmd,
	output logic [BANK_W-1:0] ba,
	output logic [ADDR_W-1:0] addr,
	output logic [1:0] up_strobe,
	output logic [1:0] lo_strobe
);
	int half = 80; // half link period, slow enough for loop off, moved in self refresh
	time t_edge; // link edge that took the last command
	// idle pins at time zero, latency left at its reset value of six
	initial
	begin
		ck = 1'b0;
		cke = 1'b1;
		cs_n = 1'b1;
		cmd = CMD_NOP;
		ba = '0;
		addr = '0;
		up_strobe = 2'b01;
		lo_strobe = 2'b01;
	end
	// free running link clock
	always #(half) ck = ~ck;
	// one command held across one rising link edge, pins scrambled after
	task send(input logic s_n, input logic [2:0] c, input logic [2:0] b,
		input logic [13:0] a, input logic k);
		@(negedge ck);
		@(posedge clk);
		cs_n <= s_n;
		cmd <= c;
		ba <= b;
		addr <= a;
		cke <= k;
		@(posedge ck);
		t_edge = $time;
		@(negedge ck);
		@(posedge clk);
		cs_n <= 1'b1;
		cmd <= CMD_NOP;
		ba <= ~b;
		addr <= ~a;
	endtask : send
	// one strobe pulse while the link clock is high or low
	task pulse(input bit upper, input bit hi);
		if (hi)
			@(posedge ck);
		else
			@(negedge ck);
		repeat (3) @(posedge clk);
		if (upper)
			up_strobe <= 2'b10;
		else
			lo_strobe <= 2'b10;
		repeat (4) @(posedge clk);
		up_strobe <= 2'b01;
		lo_strobe <= 2'b01;
	endtask : pulse
endmodule : ctrl_model

// ==== tb_dram_dll_mode_freq_change_leveling.sv ====
// testbench: idle commands, loop mode, read window, self refresh, leveling
`timescale 1ns/10ps
module tb_dram_dll_mode_freq_change_leveling
	import dram_seq_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ck, cke, cs_n;
	logic [2:0] cmd;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	logic [1:0] ups, los;
	logic dll_off, wl_active, self_refresh, dll_reset_pulse, read_window;
	logic [4:0] read_latency;
	logic [DQ_W-1:0] dq_out, dq_oe;
	int n_mismatch = 0;
	int tests_run = 0;
	time t;
	time t_rd;
	// 100 MHz system clock
	always #5 clk = ~clk;
	ctrl_model m (.clk(clk), .ck(ck), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba),
		.addr(addr), .up_strobe(ups), .lo_strobe(los));
	dram_dll_mode_freq_change_leveling DUT (.clk(clk), .sys_rst(sys_rst), .ck(ck),
		.cke(cke), .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
		.ba(ba), .addr(addr), .upper_lane_strobe_pair(ups),
		.lower_lane_strobe_pair(los), .dll_off(dll_off), .wl_active(wl_active),
		.self_refresh(self_refresh), .dll_reset_pulse(dll_reset_pulse),
		.read_window(read_window), .read_latency(read_latency), .dq_out(dq_out),
		.dq_oe(dq_oe));
	// counts, verdict and end of run
	task wrap_up;
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	// one comparison
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for a pulse: 0 read window, 1 loop reset
	task wait_for(input int sel, output time tp);
		tests_run++;
		repeat (300)
		begin
			@(negedge clk);
			if ((sel == 0 ? read_window : dll_reset_pulse) === 1'b1)
			begin
				tp = $time;
				return;
			end
		end
		n_mismatch++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		wrap_up();
	endtask : wait_for
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(16'(dll_off), 16'h0000);
		chk(16'(read_latency), 16'h0006);
		chk(dq_oe, 16'h0000);
		$display("test reset done");
		m.send(1'b0, CMD_RD, 3'h0, 14'h0000, 1'b1);
		t_rd = m.t_edge;
		m.send(1'b1, CMD_MRS, MR1_SEL, 14'h0001, 1'b1);
		m.send(1'b0, CMD_NOP, MR1_SEL, 14'h0001, 1'b1);
		wait_for(0, t);
		chk(16'((t - t_rd) / 160), 16'h0006);
		chk(16'(dll_off), 16'h0000);
		$display("test idle commands done");
		m.send(1'b0, CMD_MRS, MR1_SEL, 14'h0001, 1'b1);
		chk(16'(dll_off), 16'h0001);
		m.send(1'b0, CMD_RD, 3'h0, 14'h0000, 1'b1);
		t_rd = m.t_edge;
		wait_for(0, t);
		chk(16'((t - t_rd) / 160), 16'h0005);
		m.send(1'b0, CMD_MRS, MR1_SEL, 14'h0000, 1'b1);
		chk(16'(dll_off), 16'h0000);
		fork
			m.send(1'b0, CMD_MRS, MR0_SEL, 14'h0120, 1'b1);
			wait_for(1, t);
		join
		$display("test loop mode done");
		m.send(1'b0, CMD_REF, 3'h0, 14'h0000, 1'b0);
		chk(16'(self_refresh), 16'h0001);
		m.half = 150;
		m.send(1'b0, CMD_MRS, MR1_SEL, 14'h0001, 1'b0);
		chk(16'(dll_off), 16'h0000);
		m.half = 80;
		m.send(1'b1, CMD_NOP, 3'h0, 14'h0000, 1'b1);
		chk(16'(self_refresh), 16'h0000);
		$display("test self refresh done");
		// rewrite latencies after exit: cas code 3, additive cas minus one, then minus two
		m.send(1'b0, CMD_MRS, MR0_SEL, 14'h0030, 1'b1);
		m.send(1'b0, CMD_MRS, MR1_SEL, 14'h0008, 1'b1);
		chk(16'(read_latency), 16'h000D);
		m.send(1'b0, CMD_RD, 3'h0, 14'h0000, 1'b1);
		t_rd = m.t_edge;
		wait_for(0, t);
		chk(16'((t - t_rd) / 160), 16'h000D);
		m.send(1'b0, CMD_MRS, MR1_SEL, 14'h0010, 1'b1);
		chk(16'(read_latency), 16'h000C);
		$display("test mode rewrite done");
		m.send(1'b0, CMD_MRS, MR1_SEL, 14'h0080, 1'b1);
		chk({15'h0000, wl_active}, 16'h0001);
		chk(dq_oe, 16'hFFFF);
		m.pulse(1'b1, 1'b1);
		m.pulse(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		chk(dq_out, 16'hFF00);
		m.pulse(1'b1, 1'b0);
		m.pulse(1'b0, 1'b1);
		repeat (4) @(posedge clk);
		chk(dq_out, 16'h00FF);
		m.send(1'b0, CMD_MRS, MR1_SEL, 14'h0000, 1'b1);
		chk({15'h0000, wl_active}, 16'h0000);
		chk(dq_oe, 16'h0000);
		$display("test leveling done");
		wrap_up();
	end
endmodule : tb_dram_dll_mode_freq_change_leveling
